// ---- bench/mdpa_motor_model.sv ----
/*
 far side model: host pwm source on the speed pin.
 assumes the system clock and reset of the block under test.
*/
`timescale 1ns/100ps
module mdpa_motor_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// duty in 1/256 steps
	input wire logic [7:0] duty_i,
	// speed pin
	output logic speed_pin_o
);
	logic [13:0] pos_r;
	// ---------------------------------------------------------------
	// one period spans 256 samples of 64 clocks
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pos_r <= 14'h0000;
		end else begin
			pos_r <= pos_r + 14'h0001;
		end
	end
	assign speed_pin_o = (pos_r[13:6] < duty_i);
endmodule

// ---- bench/motor_drive_protect_amplitude_tb_top.sv ----
/*
 self-checking bench of the motor drive core with a pwm source model.
 assumes a 125 MHz clock and a short lock-off count.
*/
`timescale 1ns/100ps
module motor_drive_protect_amplitude_tb_top import mdpa_pkg::*;;
	logic clk_sys_i, reset_i, speed_pin_i, dir_i, reg_wr_i, reg_rd_i, run;
	mdpa_prot_t prot_i;
	logic [7:0] analog_speed_i, surge_limit_i, curr_limit_i, accel_limit_i, nv_speed_i;
	logic [7:0] reg_addr_i, pin_duty, peak_output_duty_o, d;
	logic [15:0] nv_cfg_i, reg_wdata_i, reg_rdata_o, rd;
	logic [2:0] phase_pwm_o;
	logic phase_hiz_o, drive_en_o, tach_out_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	int n_tach = 0;
	longint acc_m = 0;
	logic tach_q;
	// ---------------------------------------------------------------
	// instances
	// ---------------------------------------------------------------
	mdpa_core #(.LOCK_OFF_CYC(16)) u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.prot_i(prot_i), .speed_pin_i(speed_pin_i), .analog_speed_i(analog_speed_i),
		.dir_i(dir_i), .surge_limit_i(surge_limit_i), .curr_limit_i(curr_limit_i),
		.accel_limit_i(accel_limit_i), .nv_cfg_i(nv_cfg_i), .nv_speed_i(nv_speed_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .phase_pwm_o(phase_pwm_o),
		.phase_hiz_o(phase_hiz_o), .drive_en_o(drive_en_o), .tach_out_o(tach_out_o),
		.peak_output_duty_o(peak_output_duty_o));
	mdpa_motor_model u_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.duty_i(pin_duty), .speed_pin_o(speed_pin_i));
	// ---------------------------------------------------------------
	// reference model and helpers
	// ---------------------------------------------------------------
	function automatic int model_peak(int cmd);
		int m;
		m = cmd;
		if (surge_limit_i < m) m = surge_limit_i;
		if (curr_limit_i < m) m = curr_limit_i;
		if (accel_limit_i < m) m = accel_limit_i;
		return m;
	endfunction
	function automatic int model_min(int v, int mode);
		if (v >= MIN_DUTY || mode == LIM_NONE) return v;
		return (mode == LIM_OFF) ? 0 : MIN_DUTY;
	endfunction
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic reg_op(logic wr, logic [7:0] a, logic [15:0] wd);
		@(posedge clk_sys_i);
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr_i <= a;
		reg_wdata_i <= wd;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		tick(1);
		rd = reg_rdata_o;
	endtask
	task automatic wait_en(logic v, int max);
		for (int k = 0; k < max && drive_en_o !== v; k++) tick(1);
		check("drive_en", {15'h0000, drive_en_o}, {15'h0000, v});
	endtask
	// ---------------------------------------------------------------
	// clock, timeout and phase watch
	// ---------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// commutation model: electrical angle is the running sum of peak duty, six sectors a turn
	always @(posedge clk_sys_i) begin
		tach_q <= tach_out_o;
		if (reset_i) begin
			acc_m <= 0;
			n_tach <= 0;
		end else begin
			if (drive_en_o === 1'b1)
				acc_m <= acc_m + longint'(peak_output_duty_o);
			if (tach_out_o !== tach_q)
				n_tach <= n_tach + 1;
		end
	end
	always @(negedge clk_sys_i) begin
		if (run) check("phase_low", {15'h0000, &phase_pwm_o}, 16'h0000);
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h9F45));
		run = 1'b0;
		reset_i = 1'b1;
		prot_i = '0;
		prot_i.temp_below_hys = 1'b1;
		nv_cfg_i = 16'h0008;
		nv_speed_i = 8'($urandom);
		analog_speed_i = 8'($urandom);
		{surge_limit_i, curr_limit_i, accel_limit_i} = 24'hFFFFFF;
		dir_i = 1'($urandom);
		pin_duty = 8'h10;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		run <= 1'b1;
		reg_op(1'b0, ADDR_STATUS, 16'h0000);
		check("state_uv", {11'h000, rd[12:8]}, 16'h0002);
		@(posedge clk_sys_i) prot_i.uv_above_rise <= 1'b1;
		wait_en(1'b1, 4);
		check("peak_nv", {8'h00, peak_output_duty_o}, 16'(nv_speed_i));
		reg_op(1'b1, ADDR_CTRL, 16'h0000);
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			analog_speed_i <= 8'($urandom);
			surge_limit_i <= 8'($urandom);
			curr_limit_i <= 8'($urandom);
			accel_limit_i <= 8'($urandom);
			tick(3);
			check("peak", {8'h00, peak_output_duty_o}, 16'(model_peak(analog_speed_i)));
		end
		@(posedge clk_sys_i) {surge_limit_i, curr_limit_i, accel_limit_i} <= 24'hFFFFFF;
		d = 8'($urandom);
		reg_op(1'b1, ADDR_SPEED, 16'(d));
		reg_op(1'b1, ADDR_CTRL, 16'h0008);
		tick(2);
		check("peak_reg", {8'h00, peak_output_duty_o}, 16'(d));
		reg_op(1'b1, ADDR_FAULT, 16'hFFFF);
		reg_op(1'b0, ADDR_FAULT, 16'h0000);
		check("fault_ro", {13'h0000, rd[15], rd[14], rd[11]}, 16'h0000);
		reg_op(1'b0, 8'h07, 16'h0000);
		check("unmapped", rd, 16'h0000);
		reg_op(1'b0, ADDR_CTRL, 16'h0000);
		check("ctrl", rd, 16'h0008);
		@(posedge clk_sys_i) prot_i.temp_warn <= 1'b1;
		reg_op(1'b0, ADDR_FAULT, 16'h0000);
		check("warn", {15'h0000, rd[14]}, 16'h0001);
		check("warn_run", {15'h0000, drive_en_o}, 16'h0001);
		@(posedge clk_sys_i);
		prot_i.temp_over <= 1'b1;
		prot_i.temp_below_hys <= 1'b0;
		prot_i.temp_warn <= 1'b0;
		wait_en(1'b0, 4);
		reg_op(1'b0, ADDR_FAULT, 16'h0000);
		check("ot", {14'h0000, rd[15:14]}, 16'h0002);
		@(posedge clk_sys_i) prot_i.temp_over <= 1'b0;
		tick(8);
		check("ot_hys", {15'h0000, drive_en_o}, 16'h0000);
		@(posedge clk_sys_i) prot_i.temp_below_hys <= 1'b1;
		wait_en(1'b1, 4);
		@(posedge clk_sys_i) prot_i.overcurrent <= 1'b1;
		@(posedge clk_sys_i) prot_i.overcurrent <= 1'b0;
		tick(1);
		check("oc_hiz", {14'h0000, phase_hiz_o, drive_en_o}, 16'h0002);
		tick(1);
		check("oc_pwm", {13'h0000, phase_pwm_o}, 16'h0000);
		reg_op(1'b0, ADDR_FAULT, 16'h0000);
		check("oc_flag", {15'h0000, rd[11]}, 16'h0001);
		reg_op(1'b0, ADDR_FAULT, 16'h0000);
		check("oc_clear", {15'h0000, rd[11]}, 16'h0000);
		wait_en(1'b1, 24);
		for (i = 0; i < 3; i++) begin
			@(posedge clk_sys_i) prot_i.lock_detect <= 3'b001 << i;
			wait_en(1'b0, 4);
			reg_op(1'b0, ADDR_STATUS, 16'h0000);
			check("lock_stat", {3'h0, rd[12:8], 5'h00, rd[2:0]}, 16'h1000 | (16'h0001 << i));
			wait_en(1'b1, 24);
			wait_en(1'b0, 4);
			@(posedge clk_sys_i) prot_i.lock_detect <= 3'b000;
			wait_en(1'b1, 24);
		end
		@(posedge clk_sys_i);
		prot_i.uv_below_fall <= 1'b1;
		prot_i.uv_above_rise <= 1'b0;
		wait_en(1'b0, 4);
		@(posedge clk_sys_i) prot_i.uv_below_fall <= 1'b0;
		tick(4);
		check("uv_hold", {15'h0000, drive_en_o}, 16'h0000);
		reg_op(1'b0, ADDR_STATUS, 16'h0000);
		check("uv_state", {11'h000, rd[12:8]}, 16'h0002);
		@(posedge clk_sys_i) prot_i.uv_above_rise <= 1'b1;
		wait_en(1'b1, 4);
		reg_op(1'b1, ADDR_CTRL, 16'h0004);
		tick(2 * 256 * 64 + 200);
		for (i = 0; i < 4; i++) begin
			reg_op(1'b1, ADDR_CTRL, 16'h0004 | 16'(i));
			tick(3);
			check("min_duty", {8'h00, peak_output_duty_o}, 16'(model_min(pin_duty, i)));
		end
		check("tach", 16'(n_tach), 16'((3 * (acc_m >> 20)) >> 7));
		stop_test();
	end
endmodule

// ---- logic/mdpa_core.sv ----
/*
 control core of a three-phase sensorless motor driver: speed source
 selection, minimum duty, duty limiting, flat-bottom sine modulation,
 tach output and protection with fault and status registers.
 assumes comparators and the register interface are synchronous to clk_sys_i.
*/
// Functional notes
// - over-temp stops drive, flags, waits hysteresis
// - warning flag bit 14, drive continues
// - undervoltage lockout with rising release threshold
// - overcurrent floats phases, flag bit 11
// - rotor lock stops, retries after off interval
// - status shows which lock method fired
// - speed from analog, pwm pin or register
// - two-bit minimum duty mode on pwm input
// - limiters may lower peak below command
// - sine phase-to-phase, third harmonic to ground
// - one phase grounded, two modulated
// - duty value is peak, full equals supply
// - nonvolatile settings copied after power-on
// - register writes override nonvolatile settings
// - tach follows commutation frequency
// - direction taken from direction pin
`timescale 1ns/100ps
module mdpa_core import mdpa_pkg::*; #(
	parameter int unsigned LOCK_OFF_CYC = LOCK_OFF_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// protection comparators
	input wire mdpa_prot_t prot_i,
	// speed and direction inputs
	input wire logic speed_pin_i,
	input wire logic [7:0] analog_speed_i,
	input wire logic dir_i,
	// limiter requests
	input wire logic [7:0] surge_limit_i,
	input wire logic [7:0] curr_limit_i,
	input wire logic [7:0] accel_limit_i,
	// nonvolatile settings
	input wire logic [15:0] nv_cfg_i,
	input wire logic [7:0] nv_speed_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// motor side
	output logic [2:0] phase_pwm_o,
	output logic phase_hiz_o,
	output logic drive_en_o,
	output logic tach_out_o,
	output logic [7:0] peak_output_duty_o
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
		min9 = (a < b) ? a : b;
	endfunction
	function automatic logic [8:0] sin_off(input logic [7:0] a);
		logic [4:0] idx;
		logic [8:0] m;
		idx = a[6] ? 5'h10 - {1'b0, a[5:2]} : {1'b0, a[5:2]};
		m = {1'b0, SIN_Q[idx]};
		sin_off = a[7] ? SIN_MID - m : SIN_MID + m;
	endfunction
	function automatic logic [7:0] scale(input logic [8:0] d, input logic [7:0] pk);
		logic [24:0] p;
		p = 25'(d) * 25'(pk) * 25'(NORM);
		scale = (p[24:16] > SIN_MID) ? 8'hFF : p[23:16];
	endfunction
	// ---------------------------------------------------------------
	// working registers
	// ---------------------------------------------------------------
	mdpa_cfg_t cfg_r;
	logic [7:0] speed_r;
	logic load_pend_r, wr_ctrl, wr_speed, rd_fault, rd_status;
	assign wr_ctrl = reg_wr_i && reg_addr_i == ADDR_CTRL;
	assign wr_speed = reg_wr_i && reg_addr_i == ADDR_SPEED;
	assign rd_fault = reg_rd_i && reg_addr_i == ADDR_FAULT;
	assign rd_status = reg_rd_i && reg_addr_i == ADDR_STATUS;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			load_pend_r <= 1'b1;
			cfg_r <= CFG_RST;
			speed_r <= SPEED_RST;
		end else begin
			load_pend_r <= 1'b0;
			if (wr_ctrl)
				cfg_r <= reg_wdata_i;
			else if (load_pend_r)
				cfg_r <= nv_cfg_i;
			if (wr_speed)
				speed_r <= reg_wdata_i[7:0];
			else if (load_pend_r)
				speed_r <= nv_speed_i;
		end
	end
	// ---------------------------------------------------------------
	// pwm speed input duty measurement
	// ---------------------------------------------------------------
	logic [5:0] div_r;
	logic [7:0] win_r, hi_r, pwm_duty_r;
	logic samp_en, win_end;
	assign samp_en = div_r == SAMPLE_DIV_LAST;
	assign win_end = samp_en && win_r == WIN_LAST;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			div_r <= '0;
			win_r <= '0;
			hi_r <= '0;
			pwm_duty_r <= '0;
		end else begin
			div_r <= div_r + 6'h01;
			if (samp_en)
				win_r <= win_r + 8'h01;
			if (win_end) begin
				pwm_duty_r <= hi_r;
				hi_r <= '0;
			end else if (samp_en && speed_pin_i && hi_r != WIN_LAST)
				hi_r <= hi_r + 8'h01;
		end
	end
	// ---------------------------------------------------------------
	// speed command and peak duty
	// ---------------------------------------------------------------
	logic [7:0] pwm_lim, cmd, peak_nxt, peak_r;
	logic [8:0] m_a, m_b;
	logic below_min;
	assign below_min = pwm_duty_r < MIN_DUTY && cfg_r.min_duty_select != LIM_NONE;
	assign pwm_lim = !below_min ? pwm_duty_r :
		(cfg_r.min_duty_select == LIM_OFF) ? 8'h00 : MIN_DUTY;
	assign cmd = (cfg_r.speed_src == SRC_PWM) ? pwm_lim :
		(cfg_r.speed_src == SRC_I2C) ? speed_r : analog_speed_i;
	assign m_a = min9({1'b0, cmd}, {1'b0, surge_limit_i});
	assign m_b = min9({1'b0, curr_limit_i}, {1'b0, accel_limit_i});
	assign peak_nxt = 8'(min9(m_a, m_b));
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			peak_r <= '0;
		else
			peak_r <= peak_nxt;
	end
	assign peak_output_duty_o = peak_r;
	// ---------------------------------------------------------------
	// protection state machine
	// ---------------------------------------------------------------
	mdpa_state_t st_r, st_nxt;
	logic [31:0] tmr_r;
	logic tmr_load, tmr_zero, oc_r;
	logic [LOCK_W-1:0] lock_r;
	assign tmr_zero = tmr_r == 32'h0000_0000;
	always_comb begin
		st_nxt = st_r;
		tmr_load = 1'b0;
		if (prot_i.uv_below_fall)
			st_nxt = ST_UV;
		else case (st_r)
			ST_UV: if (prot_i.uv_above_rise)
				st_nxt = ST_RUN;
			ST_OT: if (prot_i.temp_below_hys)
				st_nxt = ST_RUN;
			ST_RUN: if (prot_i.temp_over)
				st_nxt = ST_OT;
			else if (prot_i.overcurrent) begin
				st_nxt = ST_OC;
				tmr_load = 1'b1;
			end else if (|prot_i.lock_detect) begin
				st_nxt = ST_LOCK;
				tmr_load = 1'b1;
			end
			ST_OC, ST_LOCK: if (prot_i.temp_over)
				st_nxt = ST_OT;
			else if (tmr_zero)
				st_nxt = ST_RUN;
			default: st_nxt = ST_UV;
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_r <= ST_UV;
			tmr_r <= '0;
			oc_r <= 1'b0;
			lock_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (tmr_load)
				tmr_r <= LOCK_OFF_CYC - 32'h0000_0001;
			else if (!tmr_zero)
				tmr_r <= tmr_r - 32'h0000_0001;
			if (st_nxt == ST_OC && st_r == ST_RUN)
				oc_r <= 1'b1;
			else if (rd_fault)
				oc_r <= 1'b0;
			if (st_nxt == ST_LOCK && st_r == ST_RUN)
				lock_r <= prot_i.lock_detect;
			else if (rd_status)
				lock_r <= '0;
		end
	end
	assign drive_en_o = st_r == ST_RUN;
	assign phase_hiz_o = st_r == ST_OC;
	// ---------------------------------------------------------------
	// register read
	// ---------------------------------------------------------------
	logic [15:0] fault_w, status_w, rd_w, rdata_r;
	assign fault_w = (16'(st_r == ST_OT) << BIT_OT) | (16'(prot_i.temp_warn) << BIT_WARN)
		| (16'(oc_r) << BIT_OC);
	assign status_w = (16'(st_r) << STAT_STATE_LSB) | 16'(lock_r);
	assign rd_w = (reg_addr_i == ADDR_FAULT) ? fault_w :
		(reg_addr_i == ADDR_STATUS) ? status_w :
		(reg_addr_i == ADDR_CTRL) ? 16'(cfg_r) :
		(reg_addr_i == ADDR_SPEED) ? 16'(speed_r) : RDATA_RST;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			rdata_r <= RDATA_RST;
		else if (reg_rd_i)
			rdata_r <= rd_w;
	end
	assign reg_rdata_o = rdata_r;
	// ---------------------------------------------------------------
	// modulation and tach
	// ---------------------------------------------------------------
	logic [ACC_W-1:0] acc_r;
	logic [7:0] carrier_r, ang [3], duty [3];
	logic [8:0] s [3], s_min;
	logic [2:0] pwm_r, sec_r;
	logic [9:0] tri3;
	logic tach_r;
	assign ang[0] = acc_r[ACC_W-1 -: 8];
	assign ang[1] = ang[0] + (dir_i ? PH_W : PH_V);
	assign ang[2] = ang[0] + (dir_i ? PH_V : PH_W);
	assign s_min = min9(min9(s[0], s[1]), s[2]);
	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_ph
		assign s[gi] = sin_off(ang[gi]);
		assign duty[gi] = scale(s[gi] - s_min, peak_r);
		always_ff @(posedge clk_sys_i) begin
			if (reset_i)
				pwm_r[gi] <= 1'b0;
			else
				pwm_r[gi] <= drive_en_o && carrier_r < duty[gi];
		end
	end
	assign tri3 = {2'b00, ang[0]} + {1'b0, ang[0], 1'b0};
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			acc_r <= '0;
			carrier_r <= '0;
			sec_r <= '0;
			tach_r <= 1'b0;
		end else begin
			carrier_r <= carrier_r + 8'h01;
			if (drive_en_o)
				acc_r <= acc_r + ACC_W'(peak_r);
			sec_r <= tri3[9:7];
			if (sec_r != tri3[9:7])
				tach_r <= ~tach_r;
		end
	end
	assign phase_pwm_o = pwm_r;
	assign tach_out_o = tach_r;
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	logic quiet;
	assign quiet = !prot_i.uv_below_fall && !prot_i.temp_over;
	sequence s_stopped;
		!drive_en_o [*4];
	endsequence
	property p_ot_shut;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_RUN && prot_i.temp_over && !prot_i.uv_below_fall |=> !drive_en_o && st_r == ST_OT;
	endproperty
	a_ot_shut: assert property (p_ot_shut) else $error("no thermal stop");
	property p_ot_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_OT && !prot_i.temp_below_hys && !prot_i.uv_below_fall |=> st_r == ST_OT;
	endproperty
	a_ot_hold: assert property (p_ot_hold) else $error("thermal left early");
	property p_warn;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_RUN && prot_i.temp_warn && quiet && !prot_i.overcurrent
		&& !(|prot_i.lock_detect) && reg_rd_i && reg_addr_i == ADDR_FAULT
		|=> drive_en_o && reg_rdata_o[BIT_WARN];
	endproperty
	a_warn: assert property (p_warn) else $error("warning bad");
	property p_uv_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		(st_r == ST_UV && !prot_i.uv_above_rise) || prot_i.uv_below_fall |=> st_r == ST_UV;
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("lockout released");
	property p_oc;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_RUN && prot_i.overcurrent && quiet |=> phase_hiz_o && oc_r ##1 phase_pwm_o == 3'b000;
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not floated");
	property p_lock_stop;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_RUN && |prot_i.lock_detect && quiet && !prot_i.overcurrent |=> s_stopped;
	endproperty
	a_lock_stop: assert property (p_lock_stop) else $error("lock not stopped");
	property p_lock_retry;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_LOCK && tmr_zero && quiet |=> drive_en_o;
	endproperty
	a_lock_retry: assert property (p_lock_retry) else $error("no retry");
	property p_lock_report;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r == ST_RUN && |prot_i.lock_detect && quiet && !prot_i.overcurrent
		|=> lock_r == $past(prot_i.lock_detect);
	endproperty
	a_lock_report: assert property (p_lock_report) else $error("lock method lost");
	property p_peak;
		@(posedge clk_sys_i) disable iff (reset_i)
		1'b1 |=> peak_r <= $past(curr_limit_i) && peak_r <= $past(surge_limit_i)
		&& peak_r <= $past(accel_limit_i);
	endproperty
	a_peak: assert property (p_peak) else $error("limit ignored");
	property p_ground;
		@(posedge clk_sys_i) disable iff (reset_i)
		drive_en_o |-> duty[0] == 8'h00 || duty[1] == 8'h00 || duty[2] == 8'h00;
	endproperty
	a_ground: assert property (p_ground) else $error("no grounded phase");
	property p_zero_peak;
		@(posedge clk_sys_i) disable iff (reset_i)
		peak_r == 8'h00 |=> phase_pwm_o == 3'b000;
	endproperty
	a_zero_peak: assert property (p_zero_peak) else $error("output without duty");
	property p_tach;
		@(posedge clk_sys_i) disable iff (reset_i)
		sec_r != tri3[9:7] |=> tach_out_o != $past(tach_out_o);
	endproperty
	a_tach: assert property (p_tach) else $error("tach missed");
endmodule

// ---- logic/mdpa_pkg.sv ----
/*
 package of the motor drive protect and amplitude block: register map,
 field layout, timing, modes, state codes and modulation constants.
 assumes a single 125 MHz system clock.
*/
package mdpa_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int LOCK_OFF_MS = 5;
	localparam int unsigned LOCK_OFF_CYC_DEF = LOCK_OFF_MS * 1000 * CLK_MHZ;
	localparam logic [5:0] SAMPLE_DIV_LAST = 6'h3F;
	localparam logic [7:0] WIN_LAST = 8'hFF;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_FAULT = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_CTRL = 8'h02;
	localparam logic [7:0] ADDR_SPEED = 8'h03;
	localparam int BIT_OT = 15;
	localparam int BIT_WARN = 14;
	localparam int BIT_OC = 11;
	localparam int LOCK_W = 3;
	localparam int STAT_STATE_LSB = 8;
	localparam logic [15:0] RDATA_RST = 16'h0000;
	localparam logic [7:0] SPEED_RST = 8'h00;
	// ---------------------------------------------------------------
	// speed sources and minimum duty modes
	// ---------------------------------------------------------------
	localparam logic [1:0] SRC_ANALOG = 2'h0;
	localparam logic [1:0] SRC_PWM = 2'h1;
	localparam logic [1:0] SRC_I2C = 2'h2;
	localparam logic [1:0] LIM_NONE = 2'h0;
	localparam logic [1:0] LIM_OFF = 2'h2;
	localparam logic [7:0] MIN_DUTY = 8'h1A;
	// ---------------------------------------------------------------
	// modulation
	// ---------------------------------------------------------------
	localparam int ACC_W = 28;
	localparam logic [7:0] PH_V = 8'h55;
	localparam logic [7:0] PH_W = 8'hAB;
	localparam logic [8:0] SIN_MID = 9'h0FF;
	localparam logic [7:0] NORM = 8'h95;
	localparam logic [7:0] SIN_Q [0:16] = '{8'h00, 8'h19, 8'h32, 8'h4A, 8'h62, 8'h78,
		8'h8E, 8'hA2, 8'hB4, 8'hC5, 8'hD4, 8'hE1, 8'hEC, 8'hF4, 8'hFA, 8'hFE, 8'hFF};
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_UV = 5'h02,
		ST_OT = 5'h04,
		ST_OC = 5'h08,
		ST_LOCK = 5'h10
	} mdpa_state_t;
	typedef struct packed {
		logic [11:0] rsvd;
		logic [1:0] speed_src;
		logic [1:0] min_duty_select;
	} mdpa_cfg_t;
	localparam mdpa_cfg_t CFG_RST = 16'h0000;
	typedef struct packed {
		logic uv_below_fall;
		logic uv_above_rise;
		logic temp_over;
		logic temp_below_hys;
		logic temp_warn;
		logic overcurrent;
		logic [2:0] lock_detect;
	} mdpa_prot_t;
endpackage
